/* File: design/sideband_defines.svh */
// Offsets, field positions, reset values and timing counts of the sideband block.
// Assumes a single 10 MHz clock; included by the package and the design modules.
//
// Contract
// - Answer 2-wire commands only while module_select_n is held low.
// - Reset input held low beyond minimum length returns all settings to defaults.
// - Completion shown by interrupt_n asserted while not-ready flag reads clear.
// - After power-up the completion interrupt is raised without any reset.
// - Transmitter off on disable pin, on serial disable request, or both.
// - Receive-loss alarm asserted while any lane is below the threshold.
// - Each lane's received power is monitored and readable over the serial bus.
// - Low-power select input sets the power consumption limit.
// - Module grounds module_present_n once inserted; host pull-up otherwise.
// - Memory map is readable and writable through the 2-wire clock and data lines.
// - Seven low-speed control and status pins, serial lines included; the block has nine, adding transmit_disable and receive_loss_alarm.
`ifndef SIDEBAND_DEFINES_SVH
`define SIDEBAND_DEFINES_SVH

// ==========================================================================
// Timing
`define CLK_MHZ          10
`define RESET_MIN_US     10
`define RESET_MIN_CYC    ((`RESET_MIN_US) * (`CLK_MHZ))
`define INIT_TIME_US     2000
`define INIT_CYC         ((`INIT_TIME_US) * (`CLK_MHZ))

// ==========================================================================
// Serial bus device address (arbitrary value)
`define DEV_ADDR         7'h50

// ==========================================================================
// Register byte offsets
`define OFS_CTRL         8'h00
`define OFS_STATUS       8'h04
`define OFS_IRQ_STAT     8'h08
`define OFS_IRQ_EN       8'h0C
`define OFS_THRESH       8'h10
`define OFS_POWER0       8'h14
`define OFS_POWER1       8'h18
`define OFS_POWER2       8'h1C
`define OFS_POWER3       8'h20

// ==========================================================================
// Field positions
`define CTRL_TXDIS_BIT   0
`define ST_NOT_READY_BIT 0
`define ST_TX_OFF_BIT    1
`define ST_LOW_PWR_BIT   2
`define ST_ALARM_BIT     3
`define ST_LOSS_LSB      4
`define IRQ_DONE_BIT     0
`define IRQ_LOSS_BIT     1

// ==========================================================================
// Reset values
`define CTRL_RST         1'h0
`define IRQ_EN_RST       2'h1
`define THRESH_RST       16'h0100
`define SYNC_W           6
`define SYNC_RST         6'h3F

`endif

/* File: design/sideband_pkg.sv */
// Types shared by the sideband control design.
// Assumes the defines header is on the include path.
`include "sideband_defines.svh"

package sideband_pkg;

  // ==========================================================================
  // Serial link phases
  typedef enum logic [8:0] {
    L_IDLE  = 9'h001,
    L_ADDR  = 9'h002,
    L_ACK_A = 9'h004,
    L_REG   = 9'h008,
    L_ACK_R = 9'h010,
    L_WR    = 9'h020,
    L_ACK_W = 9'h040,
    L_RD    = 9'h080,
    L_RACK  = 9'h100
  } link_phase_e;

  // ==========================================================================
  // Synchroniser state
  typedef struct packed {
    logic [`SYNC_W-1:0] s1;
    logic [`SYNC_W-1:0] s2;
    logic [`SYNC_W-1:0] s3;
    logic [`SYNC_W-1:0] out;
  } sync_state_s;

  // ==========================================================================
  // Control block state
  typedef struct packed {
    logic              ctrl_txdis;
    logic [1:0]        irq_stat;
    logic [1:0]        irq_en;
    logic [15:0]       thresh;
    logic [3:0][15:0]  power;
    logic [3:0]        loss;
    logic              alarm;
    logic              tx_off;
    logic              low_pwr;
    logic              irq;
    logic              not_ready;
    logic [15:0]       rst_cnt;
    logic [15:0]       init_cnt;
    logic [31:0]       rdata;
    logic              err;
    link_phase_e       phase;
    logic [3:0]        bits;
    logic [7:0]        sh;
    logic [7:0]        ptr;
    logic              rw;
    logic              nack;
    logic              sda_oe;
    logic              scl_prev;
    logic              sda_prev;
  } ctl_state_s;

endpackage : sideband_pkg

/* File: design/pin_sync.sv */
// Three-stage synchroniser for the asynchronous sideband pins.
// Assumes pins are idle high; a change is taken once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
`include "sideband_defines.svh"

module pin_sync (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic [`SYNC_W-1:0]       din,
  output logic      [`SYNC_W-1:0]       dout
);
  import sideband_pkg::*;

  localparam sync_state_s SYNC_INIT = '{s1: `SYNC_RST, s2: `SYNC_RST,
                                        s3: `SYNC_RST, out: `SYNC_RST};

  sync_state_s q;
  sync_state_s n;

  // Shift chain; output follows only where stages two and three agree
  always_comb begin
    n     = q;
    n.s1  = din;
    n.s2  = q.s1;
    n.s3  = q.s2;
    n.out = (q.out & (q.s2 ^ q.s3)) | (q.s3 & ~(q.s2 ^ q.s3));
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= SYNC_INIT;
    end else begin
      q <= n;
    end
  end

  assign dout = q.out;

endmodule : pin_sync

`default_nettype wire

/* File: design/pluggable_module_sideband_control.sv */
// Sideband control and status logic of a pluggable four-lane module.
// Assumes APB master on pclk, host pins asynchronous, lane power samples on pclk.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "sideband_defines.svh"

module pluggable_module_sideband_control #(
  parameter int unsigned INIT_CYCLES  = `INIT_CYC,
  parameter int unsigned RESET_CYCLES = `RESET_MIN_CYC
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                module_select_n,
  input  wire logic                module_reset_n,
  input  wire logic                low_power_select,
  input  wire logic                transmit_disable,
  input  wire logic                scl,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  output logic                     module_present_n,
  output logic                     interrupt_n,
  output logic                     receive_loss_alarm,
  output logic                     tx_off,
  output logic                     power_limit_low,
  input  wire logic [3:0][15:0]    lane_power
);
  import sideband_pkg::*;

  // ==========================================================================
  // Constants
  localparam logic [15:0] RMIN    = 16'(RESET_CYCLES);
  localparam logic [15:0] RSAT    = 16'(RESET_CYCLES + 1);
  localparam logic [15:0] INIT_M1 = 16'(INIT_CYCLES - 1);

  localparam ctl_state_s CTL_INIT = '{
    ctrl_txdis: `CTRL_RST,
    irq_en:     `IRQ_EN_RST,
    thresh:     `THRESH_RST,
    not_ready:  1'b1,
    tx_off:     1'b1,
    phase:      L_IDLE,
    scl_prev:   1'b1,
    sda_prev:   1'b1,
    default:    '0
  };

  // ==========================================================================
  // Pin synchronisers
  logic [`SYNC_W-1:0] pins_s;
  logic               sel_n_s;
  logic               rst_n_s;
  logic               lp_s;
  logic               txdis_s;
  logic               scl_s;
  logic               sda_s;

  pin_sync u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({sda_in, scl, transmit_disable, low_power_select,
               module_reset_n, module_select_n}),
    .dout    (pins_s)
  );

  // Split synchronised pins
  assign sel_n_s = pins_s[0];
  assign rst_n_s = pins_s[1];
  assign lp_s    = pins_s[2];
  assign txdis_s = pins_s[3];
  assign scl_s   = pins_s[4];
  assign sda_s   = pins_s[5];

  // ==========================================================================
  // Block state and lane loss compare
  ctl_state_s q;
  ctl_state_s n;
  logic [3:0] lane_low;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign lane_low[gi] = lane_power[gi] < q.thresh;
    end
  endgenerate

  // ==========================================================================
  // Register access helpers
  function automatic logic is_mapped(input logic [7:0] a);
    unique case (a)
      `OFS_CTRL, `OFS_STATUS, `OFS_IRQ_STAT, `OFS_IRQ_EN, `OFS_THRESH,
      `OFS_POWER0, `OFS_POWER1, `OFS_POWER2, `OFS_POWER3: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  function automatic logic [31:0] read_word(input ctl_state_s s, input logic [7:0] a);
    logic [31:0] w;
    w = '0;
    unique case (a)
      `OFS_CTRL:     w[`CTRL_TXDIS_BIT] = s.ctrl_txdis;
      `OFS_STATUS: begin
        w[`ST_NOT_READY_BIT]      = s.not_ready;
        w[`ST_TX_OFF_BIT]         = s.tx_off;
        w[`ST_LOW_PWR_BIT]        = s.low_pwr;
        w[`ST_ALARM_BIT]          = s.alarm;
        w[`ST_LOSS_LSB +: 4]      = s.loss;
      end
      `OFS_IRQ_STAT: w[1:0]  = s.irq_stat;
      `OFS_IRQ_EN:   w[1:0]  = s.irq_en;
      `OFS_THRESH:   w[15:0] = s.thresh;
      `OFS_POWER0:   w[15:0] = s.power[0];
      `OFS_POWER1:   w[15:0] = s.power[1];
      `OFS_POWER2:   w[15:0] = s.power[2];
      `OFS_POWER3:   w[15:0] = s.power[3];
      default:       w = '0;
    endcase
    read_word = w;
  endfunction : read_word

  // Byte-masked write; interrupt status bits are write-one-to-clear
  function automatic ctl_state_s write_word(input ctl_state_s s, input logic [7:0] a,
                                            input logic [31:0] d, input logic [3:0] be);
    ctl_state_s  r;
    logic [31:0] m;
    logic [31:0] cur;
    r   = s;
    m   = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    cur = read_word(s, a);
    cur = (cur & ~m) | (d & m);
    unique case (a)
      `OFS_CTRL:     r.ctrl_txdis = cur[`CTRL_TXDIS_BIT];
      `OFS_IRQ_STAT: r.irq_stat   = s.irq_stat & ~(d[1:0] & m[1:0]);
      `OFS_IRQ_EN:   r.irq_en     = cur[1:0];
      `OFS_THRESH:   r.thresh     = cur[15:0];
      default:       r = s;
    endcase
    write_word = r;
  endfunction : write_word

  // ==========================================================================
  // Serial bus helpers
  logic        start_c, stop_c, rise_c, fall_c;
  logic [31:0] link_word;
  logic [7:0]  link_byte, ptr_word;

  // Serial bus conditions from synchronised lines
  assign start_c   = scl_s && q.scl_prev && q.sda_prev && !sda_s;
  assign stop_c    = scl_s && q.scl_prev && !q.sda_prev && sda_s;
  assign rise_c    = scl_s && !q.scl_prev;
  assign fall_c    = !scl_s && q.scl_prev;
  assign ptr_word  = {q.ptr[7:2], 2'b00}; // Word that holds the pointed byte
  assign link_word = read_word(q, ptr_word);
  assign link_byte = link_word[{q.ptr[1:0], 3'b000} +: 8];

  // Next-state logic
  always_comb begin
    n          = q;
    n.scl_prev = scl_s;
    n.sda_prev = sda_s;

    // APB: read data captured in setup, write applied in access
    if (psel && !penable) begin
      n.rdata = read_word(q, paddr);
      n.err   = !is_mapped(paddr);
    end
    if (psel && penable && pwrite && !q.err) begin
      n = write_word(n, paddr, pwdata, 4'hF);
    end

    // Serial link
    if (sel_n_s) begin
      n.phase  = L_IDLE;
      n.sda_oe = 1'b0;
    end else if (start_c) begin
      n.phase  = L_ADDR;
      n.bits   = '0;
      n.sda_oe = 1'b0;
    end else if (stop_c) begin
      n.phase  = L_IDLE;
      n.sda_oe = 1'b0;
    end else if (rise_c) begin
      unique case (q.phase)
        L_ADDR, L_REG, L_WR: begin
          n.sh   = {q.sh[6:0], sda_s};
          n.bits = q.bits + 4'h1;
        end
        L_RD:    n.bits = q.bits + 4'h1;
        L_RACK:  n.nack = sda_s;
        default: n.bits = q.bits;
      endcase
    end else if (fall_c) begin
      unique case (q.phase)
        L_ADDR: begin
          if (q.bits == 4'h8) begin
            if (q.sh[7:1] == `DEV_ADDR) begin
              n.phase  = L_ACK_A;
              n.rw     = q.sh[0];
              n.sda_oe = 1'b1;
            end else begin
              n.phase  = L_IDLE;
            end
          end
        end
        L_ACK_A: begin
          n.bits = '0;
          if (q.rw) begin
            n.phase  = L_RD;
            n.sh     = link_byte;
            n.sda_oe = ~link_byte[7];
          end else begin
            n.phase  = L_REG;
            n.sda_oe = 1'b0;
          end
        end
        L_REG: begin
          if (q.bits == 4'h8) begin
            n.ptr    = q.sh;
            n.phase  = L_ACK_R;
            n.sda_oe = 1'b1;
          end
        end
        L_ACK_R, L_ACK_W: begin
          n.bits   = '0;
          n.phase  = L_WR;
          n.sda_oe = 1'b0;
        end
        L_WR: begin
          if (q.bits == 4'h8) begin
            n        = write_word(n, ptr_word, {4{q.sh}}, 4'(4'h1 << q.ptr[1:0]));
            n.ptr    = q.ptr + 8'h01;
            n.phase  = L_ACK_W;
            n.sda_oe = 1'b1;
          end
        end
        L_RD: begin
          if (q.bits == 4'h8) begin
            n.phase  = L_RACK;
            n.ptr    = q.ptr + 8'h01;
            n.sda_oe = 1'b0;
          end else begin
            n.sh     = {q.sh[6:0], 1'b0};
            n.sda_oe = ~q.sh[6];
          end
        end
        L_RACK: begin
          n.bits = '0;
          if (!q.nack) begin
            n.phase  = L_RD;
            n.sh     = link_byte;
            n.sda_oe = ~link_byte[7];
          end else begin
            n.phase  = L_IDLE;
          end
        end
        default: n.phase = q.phase;
      endcase
    end

    // Pin-driven status and lane monitor
    n.power   = lane_power;
    n.loss    = lane_low;
    n.alarm   = |lane_low;
    n.tx_off  = txdis_s | n.ctrl_txdis;
    n.low_pwr = lp_s;
    if (|lane_low && !q.alarm) begin
      n.irq_stat[`IRQ_LOSS_BIT] = 1'b1;
    end

    // Reset pulse length counter
    if (!rst_n_s) begin
      n.rst_cnt = (q.rst_cnt == RSAT) ? RSAT : q.rst_cnt + 16'h0001;
    end else begin
      n.rst_cnt = '0;
    end

    // Full reset once the pulse is longer than the minimum
    if (n.rst_cnt == RSAT) begin
      n.ctrl_txdis = `CTRL_RST;
      n.irq_en     = `IRQ_EN_RST;
      n.thresh     = `THRESH_RST;
      n.irq_stat   = '0;
      n.tx_off     = 1'b1;
      n.not_ready  = 1'b1;
      n.init_cnt   = '0;
    end else if (q.not_ready) begin
      if (q.init_cnt == INIT_M1) begin
        n.not_ready               = 1'b0;
        n.irq_stat[`IRQ_DONE_BIT] = 1'b1;
      end else begin
        n.init_cnt = q.init_cnt + 16'h0001;
      end
    end

    // Level interrupt from unmasked status
    n.irq = |(n.irq_stat & n.irq_en);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= CTL_INIT;
    end else begin
      q <= n;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata             = q.rdata;
  assign pready             = 1'b1;
  assign pslverr            = psel && penable && q.err;
  assign sda_out            = 1'b0;
  assign sda_oe             = q.sda_oe;
  assign module_present_n   = 1'b0;
  assign interrupt_n        = ~q.irq;
  assign receive_loss_alarm = q.alarm;
  assign tx_off             = q.tx_off;
  assign power_limit_low    = q.low_pwr;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence rst_qualify_s;
    !rst_n_s && q.rst_cnt == RMIN;
  endsequence
  sequence init_end_s;
    q.not_ready && q.init_cnt == INIT_M1 && !(!rst_n_s && q.rst_cnt == RMIN);
  endsequence
  sequence done_posted_s;
    !q.not_ready && q.irq_stat[`IRQ_DONE_BIT];
  endsequence
  full_reset_a: assert property (rst_qualify_s |=> q.not_ready && q.irq_stat == 2'h0
                                  && q.thresh == `THRESH_RST)
    else $error("long reset pulse did not restore defaults");
  short_reset_a: assert property (!q.not_ready && !rst_n_s && q.rst_cnt < RMIN
                                   |=> !q.not_ready)
    else $error("short reset pulse was not ignored");
  done_irq_a: assert property (init_end_s |=> done_posted_s ##0
                                (!interrupt_n || !q.irq_en[`IRQ_DONE_BIT]))
    else $error("reset completion not posted");
  irq_level_a: assert property (|(q.irq_stat & q.irq_en) == !interrupt_n)
    else $error("interrupt output disagrees with status");
  tx_off_a: assert property ((txdis_s || q.ctrl_txdis) |-> ##[0:1] tx_off)
    else $error("transmitter not turned off");
  loss_alarm_a: assert property (|lane_low |=> receive_loss_alarm
                                  && q.loss == $past(lane_low))
    else $error("loss alarm missing");
  deselect_idle_a: assert property (sel_n_s |=> q.phase == L_IDLE && !sda_oe)
    else $error("serial link active while deselected");
  present_a: assert property (module_present_n == 1'b0)
    else $error("present line not grounded");
  power_mon_a: assert property (1'b1 |=> q.power == $past(lane_power))
    else $error("lane power sample stale");
  low_power_a: assert property (lp_s |=> power_limit_low)
    else $error("power limit not following select");
endmodule : pluggable_module_sideband_control
`default_nettype wire

/* File: sim/host_model.sv */
// Host board model: drives the sideband pins and masters the 2-wire bus.
// Assumes an open-drain data wire with a pull-up; SCL is high for HALF clocks and low for twice HALF per bit.
`timescale 1ns/10ps
`default_nettype none
`include "sideband_defines.svh"

module host_model #(
  parameter int HALF = 10
) (
  input  wire logic pclk,
  input  wire logic sda_out,
  input  wire logic sda_oe,
  output var  logic module_select_n,
  output var  logic module_reset_n,
  output var  logic low_power_select,
  output var  logic transmit_disable,
  output var  logic scl,
  output wire logic sda_in
);
  logic sda_drv;

  // Wired-AND data level, pull-up when nobody pulls low
  assign sda_in = sda_drv & ~(sda_oe & ~sda_out);

  // Idle pin levels; this select line serves this module alone
  initial begin
    module_select_n  = 1'b0;
    module_reset_n   = 1'b1;
    low_power_select = 1'b0;
    transmit_disable = 1'b0;
    scl              = 1'b1;
    sda_drv          = 1'b1;
  end

  // ==========================================================================
  // Bus primitives
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic bit_io(input logic b, output logic r);
    cyc(HALF);
    sda_drv <= b;
    cyc(HALF);
    scl <= 1'b1;
    cyc(HALF);
    r = sda_in;
    scl <= 1'b0;
  endtask : bit_io

  task automatic byte_io(input logic [7:0] d, input logic m, output logic [7:0] r,
                         output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(m, a);
  endtask : byte_io

  task automatic start();
    cyc(HALF);
    sda_drv <= 1'b1;
    cyc(HALF);
    scl <= 1'b1;
    cyc(HALF);
    sda_drv <= 1'b0;
    cyc(HALF);
    scl <= 1'b0;
  endtask : start

  task automatic stop();
    cyc(HALF);
    sda_drv <= 1'b0;
    cyc(HALF);
    scl <= 1'b1;
    cyc(HALF);
    sda_drv <= 1'b1;
    cyc(HALF);
  endtask : stop

  // ==========================================================================
  // Transfers; nak is high if any acknowledge was missing
  task automatic i2c_write(input logic [7:0] p, input logic [7:0] d, output logic nak);
    logic [7:0] r;
    logic [2:0] a;
    start();
    byte_io({`DEV_ADDR, 1'b0}, 1'b1, r, a[0]);
    byte_io(p, 1'b1, r, a[1]);
    byte_io(d, 1'b1, r, a[2]);
    stop();
    nak = |a;
  endtask : i2c_write

  task automatic i2c_read(input logic [7:0] p, output logic [15:0] d, output logic nak);
    logic [7:0] r;
    logic [3:0] a;
    start();
    byte_io({`DEV_ADDR, 1'b0}, 1'b1, r, a[0]);
    byte_io(p, 1'b1, r, a[1]);
    start();
    byte_io({`DEV_ADDR, 1'b1}, 1'b1, r, a[2]);
    byte_io(8'hFF, 1'b0, d[7:0], a[3]);
    byte_io(8'hFF, 1'b1, d[15:8], a[3]);
    stop();
    nak = |a[2:0];
  endtask : i2c_read
endmodule : host_model
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench of the sideband block: APB master, host model, lanes.
// Assumes the package, the defines header and host_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "sideband_defines.svh"

module tb_top;
  import sideband_pkg::*;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, nak;
  logic [7:0]       paddr;
  logic [15:0]      rb;
  logic [31:0]      pwdata, prdata;
  logic             sda_out, sda_oe, module_present_n, interrupt_n;
  logic             receive_loss_alarm, tx_off, power_limit_low;
  logic             module_select_n, module_reset_n, low_power_select;
  logic             transmit_disable, scl, sda_in;
  logic [3:0][15:0] lane_power;
  logic [32:0]      exp_q[$];
  int               num_errors, samples_checked, seed;

  pluggable_module_sideband_control #(.INIT_CYCLES(20), .RESET_CYCLES(5)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .module_select_n(module_select_n), .module_reset_n(module_reset_n),
    .low_power_select(low_power_select), .transmit_disable(transmit_disable),
    .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .module_present_n(module_present_n), .interrupt_n(interrupt_n),
    .receive_loss_alarm(receive_loss_alarm), .tx_off(tx_off),
    .power_limit_low(power_limit_low), .lane_power(lane_power));

  host_model host (
    .pclk(pclk), .sda_out(sda_out), .sda_oe(sda_oe), .module_select_n(module_select_n),
    .module_reset_n(module_reset_n), .low_power_select(low_power_select),
    .transmit_disable(transmit_disable), .scl(scl), .sda_in(sda_in));

  // Clock of 100 ns period
  always #50 pclk = ~pclk;

  // ==========================================================================
  // Checking and verdict
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic check1(input logic s, input logic e);
    check({32'h0, s}, {32'h0, e});
  endtask : check1

  task automatic results();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // Read monitor: compares each completed read with the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
  end

  // ==========================================================================
  // Bus and wait helpers
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      results();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
    exp_q.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic wait_int(input logic lvl);
    int n;
    n = 0;
    while (interrupt_n !== lvl && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (interrupt_n !== lvl) begin
      num_errors++;
      results();
    end
  endtask : wait_int

  // ==========================================================================
  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    num_errors = 0;
    samples_checked = 0;
    seed = 66525;
    for (int i = 0; i < 4; i++) lane_power[i] = {1'b1, 15'($random(seed))};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wait_int(1'b0);
    check1(interrupt_n, 1'b0);
    check1(module_present_n, 1'b0);
    rd(`OFS_STATUS, 32'h0);
    rd(`OFS_IRQ_STAT, 32'h1);
    rd(`OFS_IRQ_EN, 32'h1);
    rd(8'h40, 32'h0, 1'b1);
    apb(1'b1, 8'h44, 32'hFFFF_FFFF);
    for (int i = 0; i < 4; i++) rd(`OFS_POWER0 + 8'(4 * i), {16'h0, lane_power[i]});
    // Pin and register disable, each combination
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `OFS_CTRL, {31'h0, i[1]});
      host.transmit_disable <= i[0];
      cyc(8);
      check1(tx_off, |i[1:0]);
      rd(`OFS_STATUS, {30'h0, |i[1:0], 1'b0});
    end
    apb(1'b1, `OFS_CTRL, 32'h0);
    host.transmit_disable <= 1'b0;
    host.low_power_select <= 1'b1;
    cyc(8);
    check1(power_limit_low, 1'b1);
    rd(`OFS_STATUS, 32'h4);
    host.low_power_select <= 1'b0;
    // Threshold boundary, then one lane below it
    lane_power[1] <= 16'h0100;
    cyc(4);
    check1(receive_loss_alarm, 1'b0);
    lane_power[2] <= 16'h00FF;
    cyc(4);
    check1(receive_loss_alarm, 1'b1);
    rd(`OFS_STATUS, 32'h48);
    rd(`OFS_POWER2, 32'hFF);
    // Interrupt: clear, mask, enable, clear
    rd(`OFS_IRQ_STAT, 32'h3);
    apb(1'b1, `OFS_IRQ_STAT, 32'h1);
    cyc(2);
    check1(interrupt_n, 1'b1);
    rd(`OFS_IRQ_STAT, 32'h2);
    apb(1'b1, `OFS_IRQ_EN, 32'h3);
    cyc(2);
    check1(interrupt_n, 1'b0);
    apb(1'b1, `OFS_IRQ_STAT, 32'h2);
    cyc(2);
    check1(interrupt_n, 1'b1);
    lane_power[1] <= 16'hF000;
    lane_power[2] <= 16'hF001;
    // Short reset pulse ignored, long one restores defaults
    apb(1'b1, `OFS_CTRL, 32'h1);
    apb(1'b1, `OFS_THRESH, 32'h0200);
    host.module_reset_n <= 1'b0;
    cyc(5);
    host.module_reset_n <= 1'b1;
    cyc(10);
    rd(`OFS_CTRL, 32'h1);
    rd(`OFS_THRESH, 32'h200);
    host.module_reset_n <= 1'b0;
    cyc(30);
    rd(`OFS_STATUS, 32'h3);
    host.module_reset_n <= 1'b1;
    wait_int(1'b0);
    rd(`OFS_STATUS, 32'h0);
    rd(`OFS_CTRL, 32'h0);
    rd(`OFS_THRESH, 32'h100);
    rd(`OFS_IRQ_EN, 32'h1);
    // Serial access selected, then deselected
    host.i2c_write(`OFS_THRESH, 8'h34, nak);
    check1(nak, 1'b0);
    rd(`OFS_THRESH, 32'h134);
    host.i2c_read(8'h10, rb, nak);
    check({16'h0, nak, rb}, {16'h0, 1'b0, 16'h0134});
    host.module_select_n <= 1'b1;
    cyc(8);
    host.i2c_write(`OFS_THRESH, 8'h77, nak);
    check1(nak, 1'b1);
    rd(`OFS_THRESH, 32'h134);
    cyc(2);
    results();
  end
endmodule : tb_top
`default_nettype wire
